// ===== logic/ldacr_pkg.sv
// Package: register map, field layout, reset values and types for the aux control registers
package ldacr_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_IDENT = 8'h03;
  localparam logic [7:0] ADDR_CUR_SCALE = 8'h07;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_LANE_MASK = 8'h09;
  localparam logic [7:0] ADDR_PHASE = 8'h0A;
  localparam logic [7:0] ADDR_OSC2 = 8'h7F;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CUR_SCALE = 8'hFF;
  localparam logic [7:0] RST_CONFIG = 8'h1F;
  localparam logic [7:0] RST_LANE_MASK = 8'h3F;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_OSC2 = 8'h00;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int IDENT_FIXED_BIT = 7;
  localparam int CFG_DRIVE_LSB = 3;
  localparam int CFG_FREQ_BIT = 2;
  localparam int CFG_SHORT_BIT = 0;
  localparam logic [7:0] CFG_WR_MASK = 8'h3D;
  localparam int NUM_LANES = 6;
  localparam logic [7:0] LANE_WR_MASK = 8'h3F;
  localparam int PHASE_EVEN_BIT = 7;
  localparam int OSC2_SEL_BIT = 7;
  localparam logic [7:0] OSC2_SEL_VAL = 8'h80;
  // Fractional delay denominator for stepped spread
  localparam logic [7:0] STEP_DENOM = 8'hFF;
  // Arbitrary neutral identity values
  localparam logic [3:0] MAKER_CODE_DEF = 4'hF;
  localparam logic [2:0] SPIN_DEF = 3'h0;

  typedef enum logic [2:0] {
    LDACR_F1200 = 3'b001,
    LDACR_F600 = 3'b010,
    LDACR_F800 = 3'b100
  } ldacr_freq_t;

  typedef struct packed {
    logic [7:0] cur_level;
    logic [1:0] switch_drive_strength;
    ldacr_freq_t boost_freq;
    logic short_detect_en;
  } ldacr_analog_t;

  typedef struct packed {
    logic [NUM_LANES-1:0] lane_on;
    logic even_spread_select;
    logic [6:0] delay_step_field;
    logic [2:0] lane_count;
  } ldacr_phase_t;
endpackage

// ===== logic/ldacr_lane_count.sv
// Population count of enabled lanes, latched at each period start
`timescale 1ns/1ps
module ldacr_lane_count (
  input wire logic clock,
  input wire logic srst,
  input wire logic period_start,
  input wire logic [ldacr_pkg::NUM_LANES-1:0] mask,
  output logic [2:0] count
);
  import ldacr_pkg::*;

  function automatic logic [2:0] popcnt(input logic [NUM_LANES-1:0] v);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < NUM_LANES; i++) begin
      s = s + {2'b00, v[i]};
    end
    return s;
  endfunction

  // Latched only at a period boundary so a running period keeps a steady spread
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= popcnt(RST_LANE_MASK[NUM_LANES-1:0]);
    end else if (period_start) begin
      count <= popcnt(mask);
    end
  end
endmodule

// ===== logic/ldacr_regs.sv
// Aux control register bank of the six-lane LED driver
`timescale 1ns/1ps
// Function
// - Identification byte read-only: bit7 one, maker code bits 6:3, spin 2:0.
// - Maker code 0-8 other vendors, 10-14 reserved, 15 none implemented.
// - Spin number starts at zero and counts up per revision, 0 to 7.
// - Eight-bit current scale, linear 0 to 100 percent, applied on the fly.
// - During PWM dimming the scale sets the on-interval sink current.
// - Write updates current level; read returns the applied setting.
// - Current scale resets to all ones.
// - Two-bit drive strength: 25, 50, 75, 100 percent for codes 0-3.
// - Frequency bit picks 1200kHz when zero, 600kHz when one.
// - Short detect bit off when zero, 7.5V threshold when one.
// - Configuration resets to 0x1F.
// - Mask bits 0-5 enable lanes 0-5 when one.
// - Mask read shows zero for disabled or faulted lanes.
// - Clearing then setting a faulted bit retries only that lane.
// - Mask resets to 0x3F.
// - Even spread bit set: delay is period over enabled lane count.
// - Even spread clear: delay is step value times period over 255.
// - Phase control resets to zero, giving zero delay.
// - Writing 0x80 to oscillator register picks 800kHz, overriding config.
// - Oscillator register resets to 0x00; host keeps bits 0-6 zero.
// - Reserved-bit writes do nothing except config bit 5 and oscillator bits 0-6, which are stored; defined bits read their latched value.
module ldacr_regs (
  input wire logic clock,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic [ldacr_pkg::NUM_LANES-1:0] lane_fault,
  input wire logic pwm_period_start,
  output logic [ldacr_pkg::NUM_LANES-1:0] lane_retry,
  output ldacr_pkg::ldacr_analog_t analog_ctl,
  output ldacr_pkg::ldacr_phase_t phase_ctl
);
  import ldacr_pkg::*;

  // ----------------------------------------
  // Fault input synchroniser
  // ----------------------------------------
  logic [NUM_LANES-1:0] fault_meta_r;
  logic [NUM_LANES-1:0] fault_sync_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      fault_meta_r <= '0;
      fault_sync_r <= '0;
    end else begin
      fault_meta_r <= lane_fault;
      fault_sync_r <= fault_meta_r;
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] cur_scale_r;
  logic [7:0] config_r;
  logic [7:0] lane_mask_r;
  logic [7:0] phase_r;
  logic [7:0] osc2_r;
  logic [NUM_LANES-1:0] faulted_r;
  logic [NUM_LANES-1:0] lane_retry_r;
  logic [NUM_LANES-1:0] mask_nxt;
  logic [2:0] lane_count;

  always_comb begin
    mask_nxt = wr_data[NUM_LANES-1:0] & LANE_WR_MASK[NUM_LANES-1:0];
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    return a == want;
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      cur_scale_r <= RST_CUR_SCALE;
    end else if (wr_en && hit(addr, ADDR_CUR_SCALE)) begin
      cur_scale_r <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      config_r <= RST_CONFIG;
    end else if (wr_en && hit(addr, ADDR_CONFIG)) begin
      config_r <= (wr_data & CFG_WR_MASK) | (config_r & ~CFG_WR_MASK);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lane_mask_r <= RST_LANE_MASK;
    end else if (wr_en && hit(addr, ADDR_LANE_MASK)) begin
      lane_mask_r <= {2'b00, mask_nxt};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_r <= RST_PHASE;
    end else if (wr_en && hit(addr, ADDR_PHASE)) begin
      phase_r <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      osc2_r <= RST_OSC2;
    end else if (wr_en && hit(addr, ADDR_OSC2)) begin
      osc2_r <= wr_data;
    end
  end

  // ----------------------------------------
  // Lane fault latch and retry
  // ----------------------------------------
  // A fault that arrives in the same cycle as the clearing write still wins
  generate
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      always_ff @(posedge clock) begin
        if (srst) begin
          faulted_r[g] <= 1'b0;
          lane_retry_r[g] <= 1'b0;
        end else begin
          lane_retry_r[g] <= 1'b0;
          if (fault_sync_r[g] && lane_mask_r[g]) begin
            faulted_r[g] <= 1'b1;
          end else if (wr_en && hit(addr, ADDR_LANE_MASK) && !mask_nxt[g]) begin
            faulted_r[g] <= 1'b0;
          end
          if (wr_en && hit(addr, ADDR_LANE_MASK) && mask_nxt[g] && !lane_mask_r[g]) begin
            lane_retry_r[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  ldacr_lane_count u_count (
    .clock(clock),
    .srst(srst),
    .period_start(pwm_period_start),
    .mask(lane_mask_r[NUM_LANES-1:0] & ~faulted_r),
    .count(lane_count)
  );

  // ----------------------------------------
  // Outputs to analog, boost and dimming
  // ----------------------------------------
  ldacr_freq_t freq_sel;
  always_comb begin
    if (osc2_r[OSC2_SEL_BIT]) begin
      freq_sel = LDACR_F800;
    end else if (config_r[CFG_FREQ_BIT]) begin
      freq_sel = LDACR_F600;
    end else begin
      freq_sel = LDACR_F1200;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // Reset config has the frequency bit set, so hold 600kHz to avoid a step on release
      analog_ctl <= '{RST_CUR_SCALE, 2'b11, LDACR_F600, 1'b1};
    end else begin
      analog_ctl.cur_level <= cur_scale_r;
      analog_ctl.switch_drive_strength <= config_r[CFG_DRIVE_LSB +: 2];
      analog_ctl.boost_freq <= freq_sel;
      analog_ctl.short_detect_en <= config_r[CFG_SHORT_BIT];
    end
  end

  // Step and even-spread math is done by the dimming engine from these fields
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_ctl <= '{RST_LANE_MASK[NUM_LANES-1:0], 1'b0, 7'h00, 3'h6};
    end else begin
      phase_ctl.lane_on <= lane_mask_r[NUM_LANES-1:0] & ~faulted_r;
      phase_ctl.even_spread_select <= phase_r[PHASE_EVEN_BIT];
      phase_ctl.delay_step_field <= phase_r[6:0];
      phase_ctl.lane_count <= lane_count;
    end
  end

  assign lane_retry = lane_retry_r;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    if (hit(addr, ADDR_IDENT)) begin
      rd_mux = {1'b1, MAKER_CODE_DEF, SPIN_DEF};
    end else if (hit(addr, ADDR_CUR_SCALE)) begin
      rd_mux = cur_scale_r;
    end else if (hit(addr, ADDR_CONFIG)) begin
      rd_mux = config_r;
    end else if (hit(addr, ADDR_LANE_MASK)) begin
      rd_mux = {2'b00, lane_mask_r[NUM_LANES-1:0] & ~faulted_r};
    end else if (hit(addr, ADDR_PHASE)) begin
      rd_mux = phase_r;
    end else if (hit(addr, ADDR_OSC2)) begin
      rd_mux = osc2_r;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ident_fixed;
    @(posedge clock) disable iff (srst)
      rd_en && hit(addr, ADDR_IDENT) |=> rd_valid && rd_data[IDENT_FIXED_BIT] == 1'b1;
  endproperty
  a_ident_fixed: assert property (p_ident_fixed) else $error("ident bit 7 not one");

  property p_scale_write;
    @(posedge clock) disable iff (srst)
      wr_en && hit(addr, ADDR_CUR_SCALE) |=> ##1 analog_ctl.cur_level == $past(wr_data, 2);
  endproperty
  a_scale_write: assert property (p_scale_write) else $error("current level not applied");

  property p_scale_reset;
    @(posedge clock) $fell(srst) |-> cur_scale_r == RST_CUR_SCALE && config_r == RST_CONFIG;
  endproperty
  a_scale_reset: assert property (p_scale_reset) else $error("scale or config reset wrong");

  property p_osc_override;
    @(posedge clock) disable iff (srst)
      osc2_r[OSC2_SEL_BIT] |=> analog_ctl.boost_freq == LDACR_F800;
  endproperty
  a_osc_override: assert property (p_osc_override) else $error("800kHz override lost");

  property p_freq_pick;
    @(posedge clock) disable iff (srst)
      !osc2_r[OSC2_SEL_BIT] && config_r[CFG_FREQ_BIT] |=> analog_ctl.boost_freq == LDACR_F600;
  endproperty
  a_freq_pick: assert property (p_freq_pick) else $error("600kHz not picked");

  property p_mask_read;
    @(posedge clock) disable iff (srst)
      rd_en && hit(addr, ADDR_LANE_MASK) |=> (rd_data[NUM_LANES-1:0] & $past(faulted_r)) == '0;
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("faulted lane reads one");

  property p_mask_reserved;
    @(posedge clock) disable iff (srst)
      wr_en && hit(addr, ADDR_LANE_MASK) |=> lane_mask_r == {2'b00, $past(wr_data[NUM_LANES-1:0])};
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("reserved mask bits set");

  property p_retry;
    @(posedge clock) disable iff (srst)
      wr_en && hit(addr, ADDR_LANE_MASK)
      |=> (faulted_r & ~$past(mask_nxt) & ~$past(fault_sync_r)) == '0;
  endproperty
  a_retry: assert property (p_retry) else $error("fault not cleared on disable");

  property p_count_hold;
    @(posedge clock) disable iff (srst)
      !pwm_period_start |=> $stable(lane_count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("lane count moved mid-period");

  property p_step_out;
    @(posedge clock) disable iff (srst)
      wr_en && hit(addr, ADDR_PHASE) |=> ##1 phase_ctl.delay_step_field == $past(wr_data[6:0], 2);
  endproperty
  a_step_out: assert property (p_step_out) else $error("step field not passed on");

  property p_lane_shut;
    @(posedge clock) disable iff (srst)
      |faulted_r |=> (phase_ctl.lane_on & $past(faulted_r)) == '0;
  endproperty
  a_lane_shut: assert property (p_lane_shut) else $error("faulted lane still driven");

  property p_retry_pulse;
    @(posedge clock) disable iff (srst)
      |lane_retry_r |=> (lane_retry_r & $past(lane_retry_r)) == '0;
  endproperty
  a_retry_pulse: assert property (p_retry_pulse) else $error("retry pulse too long");

  c_osc: cover property (@(posedge clock) wr_en && hit(addr, ADDR_OSC2) && wr_data == OSC2_SEL_VAL);
  c_fault: cover property (@(posedge clock) $rose(|faulted_r));
  c_retry: cover property (@(posedge clock) |lane_retry_r);
  c_even: cover property (@(posedge clock) pwm_period_start && phase_ctl.even_spread_select);
endmodule

// ===== sim/ldacr_host_model.sv
// Host controller model issuing single-byte register accesses
`timescale 1ns/1ps
module ldacr_host_model (
  input wire logic clock,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  import ldacr_pkg::*;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // Idle bus shows the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    if (a == ADDR_OSC2) x = x & OSC2_SEL_VAL;
    if (a == ADDR_PHASE && x[6:0] > 7'h33) x[6:0] = 7'h33;
    @(negedge clock);
    addr = a;
    wr_data = x;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~x;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    int n;
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    addr = ~a;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    x = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the aux control register bank
`timescale 1ns/1ps
module tb_top;
  import ldacr_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wr_en, rd_en, rd_valid, pwm_period_start;
  logic [7:0] addr, wr_data, rd_data, v, d;
  logic [5:0] lane_fault, lane_retry, seen, b;
  ldacr_analog_t analog_ctl;
  ldacr_phase_t phase_ctl;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] rst_tab [7];
  always #12.5 clock = ~clock;
  ldacr_regs dut (.clock(clock), .srst(srst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .lane_fault(lane_fault),
    .pwm_period_start(pwm_period_start), .lane_retry(lane_retry),
    .analog_ctl(analog_ctl), .phase_ctl(phase_ctl));
  ldacr_host_model host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
  // ----
  // Helpers
  // ----
  function automatic logic [7:0] f_cfg(input logic [7:0] x);
    return (x & 8'h3D) | 8'h02;
  endfunction
  function automatic logic [7:0] f_freq(input logic [7:0] c, input logic [7:0] o);
    return o[7] ? 8'h04 : (c[2] ? 8'h02 : 8'h01);
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk("read", v, e);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [7:0] x);
    host.wr(a, x);
    @(negedge clock);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard far above the under two hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    lane_fault = 6'h00;
    pwm_period_start = 1'b0;
    void'($urandom(7));
    rst_tab = '{{ADDR_IDENT, 1'b1, MAKER_CODE_DEF, SPIN_DEF}, 16'h07FF, 16'h081F,
      16'h093F, 16'h0A00, 16'h7F00, 16'h0500};
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk("freq", {5'h0, analog_ctl.boost_freq}, 8'h02);
    chk("level", analog_ctl.cur_level, 8'hFF);
    chk("short", {7'h0, analog_ctl.short_detect_en}, 8'h01);
    chk("lanes", {2'h0, phase_ctl.lane_on}, 8'h3F);
    srst = 1'b0;
    foreach (rst_tab[i]) rdc(rst_tab[i][15:8], rst_tab[i][7:0]);
    chk("drive", {6'h0, analog_ctl.switch_drive_strength}, 8'h03);
    chk("count", {5'h0, phase_ctl.lane_count}, 8'h06);
    wrs(ADDR_IDENT, 8'h00);
    rdc(ADDR_IDENT, {1'b1, MAKER_CODE_DEF, SPIN_DEF});
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($urandom));
      wrs(ADDR_CUR_SCALE, d);
      chk("level", analog_ctl.cur_level, d);
      rdc(ADDR_CUR_SCALE, d);
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      d = {v[7:5], i[1:0], i[2], v[1:0]};
      wrs(ADDR_CONFIG, d);
      chk("drive", {6'h0, analog_ctl.switch_drive_strength}, {6'h0, i[1:0]});
      chk("freq", {5'h0, analog_ctl.boost_freq}, f_freq(d, 8'h00));
      chk("short", {7'h0, analog_ctl.short_detect_en}, {7'h0, d[0]});
      rdc(ADDR_CONFIG, f_cfg(d));
    end
    wrs(ADDR_OSC2, 8'hFF);
    chk("freq", {5'h0, analog_ctl.boost_freq}, 8'h04);
    rdc(ADDR_OSC2, 8'h80);
    wrs(ADDR_OSC2, 8'h00);
    chk("freq", {5'h0, analog_ctl.boost_freq}, f_freq(d, 8'h00));
    for (int i = 0; i < 4; i++) begin
      d = {i[0], (i == 3) ? 7'h33 : 7'($urandom % 52)};
      wrs(ADDR_PHASE, d);
      chk("even", {7'h0, phase_ctl.even_spread_select}, {7'h0, d[7]});
      chk("step", {1'b0, phase_ctl.delay_step_field}, {1'b0, d[6:0]});
      rdc(ADDR_PHASE, d);
    end
    wrs(ADDR_LANE_MASK, 8'hFF);
    rdc(ADDR_LANE_MASK, 8'h3F);
    d = 8'($urandom);
    wrs(ADDR_LANE_MASK, d);
    chk("lanes", {2'h0, phase_ctl.lane_on}, d & 8'h3F);
    rdc(ADDR_LANE_MASK, d & 8'h3F);
    wrs(ADDR_LANE_MASK, 8'h3F);
    b = 6'h01 << ($urandom % 6);
    // A short fault must stay latched after the analog side lets go
    lane_fault = b;
    repeat (4) @(negedge clock);
    lane_fault = 6'h00;
    repeat (3) @(negedge clock);
    rdc(ADDR_LANE_MASK, {2'h0, ~b});
    chk("lanes", {2'h0, phase_ctl.lane_on}, {2'h0, ~b});
    host.wr(ADDR_LANE_MASK, {2'h0, ~b});
    host.wr(ADDR_LANE_MASK, 8'h3F);
    seen = lane_retry;
    repeat (3) begin
      @(negedge clock);
      seen |= lane_retry;
    end
    chk("retry", {2'h0, seen}, {2'h0, b});
    rdc(ADDR_LANE_MASK, 8'h3F);
    wrs(ADDR_LANE_MASK, 8'h07);
    chk("count", {5'h0, phase_ctl.lane_count}, 8'h06);
    pwm_period_start = 1'b1;
    @(negedge clock);
    pwm_period_start = 1'b0;
    repeat (2) @(negedge clock);
    chk("count", {5'h0, phase_ctl.lane_count}, 8'h03);
    complete_run();
  end
endmodule
